// ---- rtl/dm_pkg.sv ----
package dm_pkg;

   // Opcode fields of the data-movement instructions.
   localparam logic [7:0]  OPC_LIT_W      = 8'h0e;
   localparam logic [7:0]  OPC_LIT_BANK   = 8'h01;
   localparam logic [6:0]  OPC_STORE_W    = 7'h37;
   localparam logic [3:0]  OPC_FF_SRC     = 4'hc;
   localparam logic [3:0]  OPC_FF_DST     = 4'hf;

   // Field positions inside the 16-bit instruction word.
   localparam int          ACCESS_BIT_POS = 8;
   localparam int          FILE_MSB       = 7;
   localparam int          FULL_ADDR_MSB  = 11;

   // Address formation constants.
   localparam logic [7:0]  INDEXED_LIMIT  = 8'h5f;
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
   localparam logic [3:0]  ACCESS_LOW_PG  = 4'h0;
   localparam logic [3:0]  ACCESS_HIGH_PG = 4'hf;
   localparam logic [3:0]  BANK_UPPER_RST = 4'h0;

   // Reset values and the four phases of one instruction cycle.
   localparam logic [7:0]  WORKING_RST    = 8'h00;
   localparam logic [7:0]  BANK_RST       = 8'h00;
   localparam logic [1:0]  PH_DECODE      = 2'h0;
   localparam logic [1:0]  PH_READ        = 2'h1;
   localparam logic [1:0]  PH_PROCESS     = 2'h2;
   localparam logic [1:0]  PH_WRITE       = 2'h3;

   typedef enum logic [2:0]
   {
      OP_NONE,
      OP_LIT_W,
      OP_LIT_BANK,
      OP_STORE_W,
      OP_FF_SRC,
      OP_FF_DST
   } op_e;

   // Data memory request as seen by the memory.
   typedef struct packed
   {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } mem_req_s;

endpackage

// ---- rtl/bank_address_resolver.sv ----
`timescale 1ns/1ps
`default_nettype none
module bank_address_resolver
(
   // Operand fields.
   input  wire logic [7:0]  file_addr,
   input  wire logic        access_sel,
   // Addressing context.
   input  wire logic        ext_set,
   input  wire logic [3:0]  bank_low,
   input  wire logic [11:0] index_base,
   // Resolved address.
   output logic      [11:0] data_addr,
   output logic             indexed
);
   import dm_pkg::*;

   // Pick one of the three addressing forms of a file-register operand.
   always_comb
   begin
      indexed = ext_set && !access_sel && (file_addr <= INDEXED_LIMIT);
      if (indexed)
      begin
         data_addr = index_base + {4'h0, file_addr};
      end
      else if (access_sel)
      begin
         data_addr = {bank_low, file_addr};
      end
      else if (file_addr < ACCESS_SPLIT)
      begin
         data_addr = {ACCESS_LOW_PG, file_addr};
      end
      else
      begin
         data_addr = {ACCESS_HIGH_PG, file_addr};
      end
   end
endmodule
`default_nettype wire

// ---- rtl/data_move_instruction_decoder.sv ----
// What this block does
// - Literal load copies the 8-bit immediate unchanged into the working register.
// - Store opcode is decoded and the working register written to the file register.
// - The store's 8-bit file address reaches any byte of one 256-byte bank.
// - Access selector zero resolves the address inside the fixed access bank.
// - Access selector one uses the bank select register to pick the bank.
// - Extended set, selector zero, address up to 95: indexed literal offset mode.
// - Bank literal load writes the bank select register for later instructions.
// - Two-word move takes full 12-bit source and destination addresses.
`timescale 1ns/1ps
`default_nettype none
module data_move_instruction_decoder
#(
   parameter logic [11:0] WORKING_ADDR = 12'hfff
)
(
   // Clock, reset and enable.
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   // Instruction fetch.
   input  wire logic              instr_valid,
   input  wire logic [15:0]       instr,
   // Addressing context.
   input  wire logic              ext_set,
   input  wire logic [11:0]       index_base,
   // Data memory.
   output dm_pkg::mem_req_s       mem_req,
   input  wire logic [7:0]        mem_rdata,
   // Core state.
   output logic      [7:0]        working_reg,
   output logic      [7:0]        bank_select_register,
   output logic      [1:0]        phase,
   output logic                   instr_done
);
   import dm_pkg::*;

   typedef struct packed
   {
      logic [1:0]  phase;
      op_e         op;
      logic [15:0] ir;
      logic        ext;
      logic [11:0] idx;
      logic [7:0]  data;
      logic        ff_pending;
      logic [7:0]  w;
      logic [7:0]  bank_sel;
      mem_req_s    mem;
      logic        done;
   } state_s;

   state_s     st_q;
   state_s     st_d;
   logic       rst_meta_q;
   logic       rst_sync_q;
   logic [11:0] res_addr;
   logic       res_indexed;

   // Reset is released through two flops so every state flop leaves reset on one edge.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Operand address of the single-word store.
   bank_address_resolver u_resolver
   (
      .file_addr  (st_q.ir[FILE_MSB:0]),
      .access_sel (st_q.ir[ACCESS_BIT_POS]),
      .ext_set    (st_q.ext),
      .bank_low   (st_q.bank_sel[3:0]),
      .index_base (st_q.idx),
      .data_addr  (res_addr),
      .indexed    (res_indexed)
   );

   // One pass through the four phases per instruction word; strobes last one phase.
   always_comb
   begin
      st_d = st_q;
      st_d.phase = st_q.phase + 2'h1;
      st_d.mem.we = 1'b0;
      st_d.mem.re = 1'b0;
      st_d.done = 1'b0;
      case (st_q.phase)
         PH_DECODE:
         begin
            st_d.op = OP_NONE;
            st_d.ext = ext_set;
            st_d.idx = index_base;
            if (instr_valid)
            begin
               st_d.ir = instr;
               if (st_q.ff_pending)
               begin
                  // A missing second word abandons the move instead of writing garbage.
                  st_d.ff_pending = 1'b0;
                  if (instr[15:12] == OPC_FF_DST)
                  begin
                     st_d.op = OP_FF_DST;
                  end
               end
               else if (instr[15:8] == OPC_LIT_W)
               begin
                  st_d.op = OP_LIT_W;
               end
               else if (instr[15:8] == OPC_LIT_BANK)
               begin
                  st_d.op = OP_LIT_BANK;
               end
               else if (instr[15:9] == OPC_STORE_W)
               begin
                  st_d.op = OP_STORE_W;
               end
               else if (instr[15:12] == OPC_FF_SRC)
               begin
                  st_d.op = OP_FF_SRC;
               end
            end
         end
         PH_READ:
         begin
            // The working register is not in memory here, so a read of it is skipped.
            if (st_q.op == OP_FF_SRC && st_q.ir[FULL_ADDR_MSB:0] != WORKING_ADDR)
            begin
               st_d.mem.re = 1'b1;
               st_d.mem.addr = st_q.ir[FULL_ADDR_MSB:0];
            end
         end
         PH_PROCESS:
         begin
            case (st_q.op)
               OP_FF_SRC:
               begin
                  st_d.data = st_q.mem.re ? mem_rdata : st_q.w;
                  st_d.ff_pending = 1'b1;
               end
               OP_STORE_W:
               begin
                  st_d.mem.we = 1'b1;
                  st_d.mem.addr = res_addr;
                  st_d.mem.wdata = st_q.w;
               end
               OP_FF_DST:
               begin
                  if (st_q.ir[FULL_ADDR_MSB:0] != WORKING_ADDR)
                  begin
                     st_d.mem.we = 1'b1;
                     st_d.mem.addr = st_q.ir[FULL_ADDR_MSB:0];
                     st_d.mem.wdata = st_q.data;
                  end
               end
               default:
               begin
                  st_d.data = st_q.data;
               end
            endcase
         end
         PH_WRITE:
         begin
            st_d.done = (st_q.op != OP_NONE) && (st_q.op != OP_FF_SRC);
            case (st_q.op)
               OP_LIT_W:
               begin
                  st_d.w = st_q.ir[7:0];
               end
               OP_LIT_BANK:
               begin
                  st_d.bank_sel = {BANK_UPPER_RST, st_q.ir[3:0]};
               end
               OP_FF_DST:
               begin
                  if (st_q.ir[FULL_ADDR_MSB:0] == WORKING_ADDR)
                  begin
                     st_d.w = st_q.data;
                  end
               end
               default:
               begin
                  st_d.w = st_q.w;
               end
            endcase
         end
         default:
         begin
            st_d.phase = PH_DECODE;
         end
      endcase
   end

   // All block state, frozen while the enable is low.
   always_ff @(posedge ref_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         st_q <= '{phase: PH_DECODE, op: OP_NONE, w: WORKING_RST, bank_sel: BANK_RST, default: '0};
      end
      else if (ce)
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state flops.
   assign mem_req              = st_q.mem;
   assign working_reg          = st_q.w;
   assign bank_select_register = st_q.bank_sel;
   assign phase                = st_q.phase;
   assign instr_done           = st_q.done;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_sync_q);

   lit_w_load_a: assert property (
      ce && st_q.phase == PH_WRITE && st_q.op == OP_LIT_W |=> working_reg == $past(st_q.ir[7:0]))
      else $error("literal not loaded into working register");

   store_decode_a: assert property (
      ce && st_q.phase == PH_DECODE && instr_valid && !st_q.ff_pending
      && instr[15:9] == OPC_STORE_W |=> st_q.op == OP_STORE_W ##1 1'b1)
      else $error("store opcode not decoded");

   store_write_a: assert property (
      ce && st_q.phase == PH_PROCESS && st_q.op == OP_STORE_W
      |=> mem_req.we && mem_req.wdata == working_reg && phase == PH_WRITE)
      else $error("store did not write the working register");

   bank_range_a: assert property (
      mem_req.we && st_q.op == OP_STORE_W && !res_indexed |-> mem_req.addr[7:0] == st_q.ir[7:0])
      else $error("store address outside the addressed bank byte");

   access_bank_a: assert property (
      mem_req.we && st_q.op == OP_STORE_W && !st_q.ir[ACCESS_BIT_POS] && !res_indexed
      |-> mem_req.addr[11:8] == (st_q.ir[7] ? ACCESS_HIGH_PG : ACCESS_LOW_PG))
      else $error("access bank address wrong");

   bank_select_a: assert property (
      mem_req.we && st_q.op == OP_STORE_W && st_q.ir[ACCESS_BIT_POS]
      |-> mem_req.addr[11:8] == bank_select_register[3:0])
      else $error("bank select not used for store");

   indexed_mode_a: assert property (
      mem_req.we && st_q.op == OP_STORE_W && st_q.ext && !st_q.ir[ACCESS_BIT_POS]
      && st_q.ir[7:0] <= INDEXED_LIMIT |-> mem_req.addr == st_q.idx + {4'h0, st_q.ir[7:0]})
      else $error("indexed literal offset address wrong");

   bank_load_a: assert property (
      ce && st_q.phase == PH_WRITE && st_q.op == OP_LIT_BANK
      |=> bank_select_register == {4'h0, $past(st_q.ir[3:0])} && instr_done)
      else $error("bank select register not loaded");

   bank_upper_a: assert property (
      bank_select_register[7:4] == BANK_UPPER_RST && !(st_q.op == OP_LIT_BANK && mem_req.we))
      else $error("bank select upper bits not zero");

   move_dest_a: assert property (
      mem_req.we && st_q.op == OP_FF_DST |-> mem_req.addr == st_q.ir[11:0]
      && mem_req.wdata == st_q.data)
      else $error("two-word move wrote wrong address or data");

   store_seen_c: cover property (mem_req.we && st_q.op == OP_STORE_W && res_indexed);
   move_seen_c: cover property (mem_req.we && st_q.op == OP_FF_DST);
   bank_seen_c: cover property (instr_done && bank_select_register != BANK_RST);
endmodule
`default_nettype wire

// ---- sim/data_move_instruction_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module data_move_instruction_decoder_tb;
   import dm_pkg::*;

   logic             ref_clk = 1'b0;
   logic             nrst = 1'b0;
   logic             ce = 1'b1;
   logic             instr_valid = 1'b0;
   logic [15:0]      instr = 16'h0000;
   logic             ext_set = 1'b0;
   logic [11:0]      index_base = 12'h000;
   logic [7:0]       mem_rdata = 8'h00;
   mem_req_s         mem_req;
   logic [7:0]       working_reg;
   logic [7:0]       bank_select_register;
   logic [1:0]       phase;
   logic             instr_done;
   int               fail_count = 0;
   int               checks_done = 0;
   int               cycles = 0;
   logic [3:0]       we_n, re_n, dn_n;
   logic [11:0]      we_a, re_a;
   logic [7:0]       we_d, w_m;

   // Address at which the working register stands in for memory during a move.
   localparam logic [11:0] WORK_ADDR = 12'hfff;

   data_move_instruction_decoder
   #(
      .WORKING_ADDR (WORK_ADDR)
   )
   u_dut
   (
      .ref_clk              (ref_clk),
      .nrst                 (nrst),
      .ce                   (ce),
      .instr_valid          (instr_valid),
      .instr                (instr),
      .ext_set              (ext_set),
      .index_base           (index_base),
      .mem_req              (mem_req),
      .mem_rdata            (mem_rdata),
      .working_reg          (working_reg),
      .bank_select_register (bank_select_register),
      .phase                (phase),
      .instr_done           (instr_done)
   );

   // Free running 125 MHz clock.
   always #4 ref_clk = ~ref_clk;

   // A hung handshake ends the run here instead of stalling forever.
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         test_done();
      end
   end

   task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Present one word so that the next edge in phase zero takes it.
   task automatic send(input logic [15:0] w);
      int n;
      n = 0;
      // Step off any clock edge first, so phase is read only once it has settled.
      #1;
      while (phase !== 2'h3 && n < 8)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (phase !== 2'h3)
      begin
         fail_count++;
         $display("ERROR send phase expected 3 seen %h", phase);
      end
      @(posedge ref_clk);
      instr <= w;
      instr_valid <= 1'b1;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
   endtask

   // Scan settled outputs, so the check does not hinge on the exact latency.
   task automatic watch(input int n);
      we_n = 4'h0;
      re_n = 4'h0;
      dn_n = 4'h0;
      repeat (n)
      begin
         @(posedge ref_clk);
         #1;
         if (mem_req.we === 1'b1)
         begin
            we_n = we_n + 4'h1;
            we_a = mem_req.addr;
            we_d = mem_req.wdata;
         end
         if (mem_req.re === 1'b1)
         begin
            re_n = re_n + 4'h1;
            re_a = mem_req.addr;
         end
         if (instr_done === 1'b1)
            dn_n = dn_n + 4'h1;
      end
   endtask

   task automatic op(input logic [15:0] w, input logic [3:0] we_e, input logic [11:0] a_e);
      send(w);
      watch(5);
      chk("write count", 22'(we_e), 22'(we_n));
      if (we_e != 4'h0)
      begin
         chk("write address", 22'(a_e), 22'(we_a));
         chk("write data", 22'(w_m), 22'(we_d));
      end
      chk("done count", 22'h1, 22'(dn_n));
   endtask

   task automatic lit(input logic [7:0] k);
      w_m = k;
      op({OPC_LIT_W, k}, 4'h0, 12'h000);
      chk("working", 22'(k), 22'(working_reg));
   endtask

   // Hold reset for the given number of edges, check the reset state, then release it.
   task automatic test_reset(input int hold);
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (hold) @(posedge ref_clk);
      #1;
      chk("reset request", 22'h0, mem_req);
      chk("reset working", 22'(WORKING_RST), 22'(working_reg));
      chk("reset bank", 22'(BANK_RST), 22'(bank_select_register));
      chk("reset phase", 22'(PH_DECODE), 22'(phase));
      chk("reset done", 22'h0, 22'(instr_done));
      @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      $display("test reset finished");
   endtask

   task automatic test_literal();
      lit(8'h00);
      lit(8'h5a);
      lit(8'hff);
      op({OPC_LIT_BANK, 8'hf5}, 4'h0, 12'h000);
      chk("bank upper kept", 22'h05, 22'(bank_select_register));
      chk("working kept", 22'hff, 22'(working_reg));
      op({OPC_LIT_BANK, 8'h0a}, 4'h0, 12'h000);
      chk("bank", 22'h0a, 22'(bank_select_register));
      $display("test literal finished");
   endtask

   task automatic test_store();
      lit(8'h4f);
      op({OPC_STORE_W, 1'b1, 8'hff}, 4'h1, 12'haff);
      op({OPC_STORE_W, 1'b1, 8'h00}, 4'h1, 12'ha00);
      op({OPC_STORE_W, 1'b0, 8'h10}, 4'h1, 12'h010);
      op({OPC_STORE_W, 1'b0, 8'h90}, 4'h1, 12'hf90);
      @(posedge ref_clk);
      ext_set <= 1'b1;
      index_base <= 12'hff0;
      op({OPC_STORE_W, 1'b0, 8'h5f}, 4'h1, 12'h04f);
      op({OPC_STORE_W, 1'b0, 8'h60}, 4'h1, 12'h060);
      op({OPC_STORE_W, 1'b1, 8'h10}, 4'h1, 12'ha10);
      @(posedge ref_clk);
      ext_set <= 1'b0;
      $display("test store finished");
   endtask

   // The second word is the next word taken; idle slots in between keep the move pending.
   task automatic test_move();
      @(posedge ref_clk);
      mem_rdata <= 8'h33;
      send({OPC_FF_SRC, 12'h123});
      watch(3);
      chk("move read count", 22'h1, 22'(re_n));
      chk("move read address", 22'h123, 22'(re_a));
      chk("move first done", 22'h0, 22'(dn_n));
      send({OPC_FF_DST, 12'hfe6});
      watch(5);
      chk("move write count", 22'h1, 22'(we_n));
      chk("move write address", 22'hfe6, 22'(we_a));
      chk("move write data", 22'h33, 22'(we_d));
      chk("move done", 22'h1, 22'(dn_n));
      send({OPC_FF_SRC, 12'h0ab});
      watch(3);
      send({OPC_FF_DST, WORK_ADDR});
      watch(5);
      chk("move to working writes", 22'h0, 22'(we_n));
      chk("move to working", 22'h33, 22'(working_reg));
      // Memory data changes so a read of memory instead of the working register shows.
      @(posedge ref_clk);
      mem_rdata <= 8'h5c;
      send({OPC_FF_SRC, WORK_ADDR});
      watch(3);
      chk("move from working reads", 22'h0, 22'(re_n));
      send({OPC_FF_DST, 12'h200});
      watch(5);
      chk("move from working writes", 22'h1, 22'(we_n));
      chk("move from working address", 22'h200, 22'(we_a));
      chk("move from working data", 22'h33, 22'(we_d));
      send({OPC_FF_SRC, 12'h010});
      watch(3);
      send({OPC_LIT_W, 8'h77});
      watch(5);
      chk("dropped move done", 22'h0, 22'(dn_n));
      chk("dropped move working", 22'h33, 22'(working_reg));
      $display("test move finished");
   endtask

   task automatic test_enable();
      logic [1:0] p;
      @(posedge ref_clk);
      ce <= 1'b0;
      #1;
      p = phase;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("frozen phase", 22'(p), 22'(phase));
      @(posedge ref_clk);
      ce <= 1'b1;
      lit(8'h81);
      $display("test enable finished");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence: reset held for fourteen cycles, each scenario in turn, then a
   // second reset in mid-run, which must clear loaded registers and leave the core running.
   initial
   begin
      test_reset(14);
      test_literal();
      test_store();
      test_move();
      test_enable();
      test_reset(3);
      lit(8'h3c);
      test_done();
   end
endmodule
`default_nettype wire
